// File: core/dac_output_slew_control.sv
// Functional notes
// - In modem current mode, delay bit picks 4 ms (0) or 200 us (1).
// - In plain current or voltage mode the delay is always 200 us.
// - Read-only settled flag, reset 1, high when compliant generator equals active code.
// - Compliant generator runs always, even when slewing is off or linear.
// - Leaving high impedance loads the offset code and drops settled until resettled.
// - Slew select 00 off, 01 linear, 10 compliant.
// - Linear step 0.8, 1.5, 6.1 or 22.2 percent of full scale.
// - Linear rate 4.8, 76.8, 153.6 or 230.4 kHz.
// - Current limit bit picks 16 mA (0) or 8 mA (1) in voltage mode.
// - Deferred bit holds target writes until the update key is written.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module dac_output_slew_control #(
  // Cycle counts of the drive delays, the linear rate 0 period and the compliant tick period.
  parameter longint LONG_DLY = slew_ctrl_pkg::LONG_DLY_CYC,
  parameter longint SHORT_DLY = slew_ctrl_pkg::SHORT_DLY_CYC,
  parameter longint RATE0 = slew_ctrl_pkg::RATE0_CYC,
  parameter longint COMPL_TICK = slew_ctrl_pkg::COMPL_CYC
) (
  // Clock, reset and enable, the bus slave, then the controls of the output stage.
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [15:0] dac_code,
  output logic bias_enable,
  output logic driver_enable,
  output logic voltage_range_bipolar,
  output logic current_limit_low,
  output logic irq
);

  // Moves a code one step toward a goal, landing on the goal exactly.
  function automatic logic [15:0] approach(input logic [15:0] cur, input logic [15:0] goal,
                                           input logic [15:0] step);
    logic [15:0] diff;
    diff = (cur > goal) ? (cur - goal) : (goal - cur);
    if (diff <= step) begin
      approach = goal;
    end else if (cur > goal) begin
      approach = cur - step;
    end else begin
      approach = cur + step;
    end
  endfunction : approach

  // Merges write data into a register on the selected byte lanes only.
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wdat,
                                             input logic [15:0] lanes);
    lane_merge = (old & ~lanes) | (wdat & lanes);
  endfunction : lane_merge

  // True when a function code selects high impedance.
  function automatic logic is_hiz(input logic [1:0] fn);
    is_hiz = (fn == 2'(slew_ctrl_pkg::high_impedance_function));
  endfunction : is_hiz

  // Channel state held in flip-flops, plus the combinational event vector.
  slew_ctrl_pkg::setup_s setup_reg;
  slew_ctrl_pkg::channel_function_e func_reg;
  logic [15:0] target_reg;
  logic [15:0] staged_reg;
  logic [15:0] active_reg;
  logic [15:0] gen_reg;
  logic settled_reg;
  logic kick_reg;
  logic [19:0] lin_cnt_reg;
  logic [19:0] gen_cnt_reg;
  logic [19:0] dly_cnt_reg;
  logic dly_run_reg;
  logic [slew_ctrl_pkg::EV_COUNT-1:0] irq_stat_reg;
  logic [slew_ctrl_pkg::EV_COUNT-1:0] irq_mask_reg;
  logic [slew_ctrl_pkg::EV_COUNT-1:0] events;

  // Bus decode; a request is taken once, the answer comes one cycle later.
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i;
  wire [15:0] wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire wr_setup = wr & (adr_i == slew_ctrl_pkg::OFS_SETUP);
  wire wr_func = wr & (adr_i == slew_ctrl_pkg::OFS_FUNC) & sel_i[0];
  wire wr_target = wr & (adr_i == slew_ctrl_pkg::OFS_TARGET);
  wire wr_key = wr & (adr_i == slew_ctrl_pkg::OFS_KEY);
  wire wr_istat = wr & (adr_i == slew_ctrl_pkg::OFS_IRQ_STAT) & sel_i[0];
  wire wr_imask = wr & (adr_i == slew_ctrl_pkg::OFS_IRQ_MASK) & sel_i[0];

  // Merged write values honouring the byte lanes.
  wire [15:0] setup_wr = lane_merge(setup_reg, dat_i[15:0], wmask);
  wire [15:0] target_wr = lane_merge(target_reg, dat_i[15:0], wmask);
  wire [15:0] staged_wr = lane_merge(staged_reg, dat_i[15:0], wmask);
  wire key_ok = wr_key & sel_i[0] & sel_i[1] & (dat_i[15:0] == slew_ctrl_pkg::UPDATE_KEY);

  // Function change and bias sequencing decode.
  wire [1:0] func_wr = dat_i[1:0];
  wire leave_hiz = wr_func && is_hiz(2'(func_reg)) && !is_hiz(func_wr);
  wire go_hiz = wr_func && is_hiz(func_wr);
  wire func_change = wr_func && (func_wr != 2'(func_reg));
  wire long_dly = (func_wr == 2'(slew_ctrl_pkg::current_out_with_modem))
                  && !setup_reg.drive_enable_delay_sel;
  wire [19:0] dly_load = long_dly ? 20'(LONG_DLY - 1) : 20'(SHORT_DLY - 1);

  // Target path: immediate or held until the update key.
  wire tgt_now = wr_target & ~setup_reg.deferred_update_enable;
  wire tgt_key = key_ok & setup_reg.deferred_update_enable;

  // Linear slew period and step selection.
  wire [19:0] lin_period = (setup_reg.lin_rate_sel == 2'h0) ? 20'(RATE0) :
                           (setup_reg.lin_rate_sel == 2'h1) ? slew_ctrl_pkg::RATE1_CYC :
                           (setup_reg.lin_rate_sel == 2'h2) ? slew_ctrl_pkg::RATE2_CYC :
                           slew_ctrl_pkg::RATE3_CYC;
  wire [15:0] lin_step = (setup_reg.lin_step_sel == 2'h0) ? slew_ctrl_pkg::STEP0 :
                         (setup_reg.lin_step_sel == 2'h1) ? slew_ctrl_pkg::STEP1 :
                         (setup_reg.lin_step_sel == 2'h2) ? slew_ctrl_pkg::STEP2 :
                         slew_ctrl_pkg::STEP3;
  wire lin_tick = (lin_cnt_reg >= lin_period - 20'h00001);
  wire gen_tick = (gen_cnt_reg >= 20'(COMPL_TICK - 1));

  // Slew mode decode.
  wire mode_off = (setup_reg.slew_sel == slew_ctrl_pkg::SLEW_OFF);
  wire mode_lin = (setup_reg.slew_sel == slew_ctrl_pkg::SLEW_LINEAR);
  wire mode_cpl = (setup_reg.slew_sel == slew_ctrl_pkg::compliant_slew_mode);

  // Compliant generator goal: the target when it drives, else the active code.
  wire [15:0] gen_goal = mode_cpl ? target_reg : active_reg;
  wire [15:0] gen_next = approach(gen_reg, gen_goal, slew_ctrl_pkg::COMPL_STEP);
  wire [15:0] lin_next = approach(active_reg, target_reg, lin_step);
  wire settled_next = (gen_reg == active_reg) && !kick_reg && !leave_hiz;

  // Active code selection per slew mode.
  logic [15:0] active_next;
  always_comb begin
    active_next = active_reg;
    if (leave_hiz) begin
      active_next = slew_ctrl_pkg::OFFSET_CODE;
    end else if (mode_off) begin
      active_next = target_reg;
    end else if (mode_lin && lin_tick) begin
      active_next = lin_next;
    end else if (mode_cpl) begin
      active_next = gen_reg;
    end
  end

  // Events feeding the sticky status bits.
  assign events[slew_ctrl_pkg::EV_SETTLED] = settled_next & ~settled_reg;
  assign events[slew_ctrl_pkg::EV_DRIVE_ON] = dly_run_reg && (dly_cnt_reg == 20'h00000);
  assign events[slew_ctrl_pkg::EV_LIN_DONE] = mode_lin && lin_tick && (active_reg != target_reg)
                                              && (lin_next == target_reg);

  // Bits cleared by a status write, and the masked interrupt level.
  wire [slew_ctrl_pkg::EV_COUNT-1:0] stat_clear = wr_istat ? dat_i[slew_ctrl_pkg::EV_COUNT-1:0] : '0;
  wire irq_next = |(irq_stat_reg & irq_mask_reg);

  // Read data mux; unmapped addresses read zero.
  wire [15:0] setup_rd = {setup_reg[15:9], settled_reg, setup_reg[7:0]} & 16'h07FF;
  wire [31:0] rd_data = (adr_i == slew_ctrl_pkg::OFS_SETUP) ? {16'h0000, setup_rd} :
                        (adr_i == slew_ctrl_pkg::OFS_FUNC) ? {30'h00000000, func_reg} :
                        (adr_i == slew_ctrl_pkg::OFS_TARGET) ? {16'h0000, target_reg} :
                        (adr_i == slew_ctrl_pkg::OFS_STATE) ?
                          {14'h0000, driver_enable, bias_enable, active_reg} :
                        (adr_i == slew_ctrl_pkg::OFS_IRQ_STAT) ? {29'h00000000, irq_stat_reg} :
                        (adr_i == slew_ctrl_pkg::OFS_IRQ_MASK) ? {29'h00000000, irq_mask_reg} :
                        32'h00000000;

  // Bus answer: one-cycle acknowledge, read data latched with it.
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce) begin
      ack_o <= req;
      dat_o <= req ? rd_data : 32'h00000000;
    end
  end

  // Setup and function registers; the settled bit is never written.
  always_ff @(posedge clock) begin
    if (rst) begin
      setup_reg <= slew_ctrl_pkg::SETUP_RESET & slew_ctrl_pkg::SETUP_RW_MASK;
      func_reg <= slew_ctrl_pkg::high_impedance_function;
    end else if (ce) begin
      if (wr_setup) begin
        setup_reg <= setup_wr & slew_ctrl_pkg::SETUP_RW_MASK;
      end
      if (wr_func) begin
        func_reg <= slew_ctrl_pkg::channel_function_e'(func_wr);
      end
    end
  end

  // Target and staged codes.
  always_ff @(posedge clock) begin
    if (rst) begin
      target_reg <= 16'h0000;
      staged_reg <= 16'h0000;
    end else if (ce) begin
      if (wr_target) begin
        staged_reg <= staged_wr;
      end
      if (leave_hiz) begin
        target_reg <= slew_ctrl_pkg::OFFSET_CODE;
      end else if (tgt_now) begin
        target_reg <= target_wr;
      end else if (tgt_key) begin
        target_reg <= staged_reg;
      end
    end
  end

  // Active code, compliant generator and settled flag.
  always_ff @(posedge clock) begin
    if (rst) begin
      active_reg <= 16'h0000;
      gen_reg <= 16'h0000;
      settled_reg <= 1'b1;
      kick_reg <= 1'b0;
    end else if (ce) begin
      active_reg <= active_next;
      if (gen_tick) begin
        gen_reg <= gen_next;
      end
      settled_reg <= settled_next;
      kick_reg <= leave_hiz | (kick_reg & ~gen_tick);
    end
  end

  // Free-running tick counters for linear slew and the compliant generator.
  always_ff @(posedge clock) begin
    if (rst) begin
      lin_cnt_reg <= 20'h00000;
      gen_cnt_reg <= 20'h00000;
    end else if (ce) begin
      lin_cnt_reg <= lin_tick ? 20'h00000 : lin_cnt_reg + 20'h00001;
      gen_cnt_reg <= gen_tick ? 20'h00000 : gen_cnt_reg + 20'h00001;
    end
  end

  // Bias first, then the driver after the selected delay.
  always_ff @(posedge clock) begin
    if (rst) begin
      bias_enable <= 1'b0;
      driver_enable <= 1'b0;
      dly_run_reg <= 1'b0;
      dly_cnt_reg <= 20'h00000;
    end else if (ce) begin
      if (go_hiz) begin
        bias_enable <= 1'b0;
        driver_enable <= 1'b0;
        dly_run_reg <= 1'b0;
      end else if (func_change) begin
        bias_enable <= 1'b1;
        driver_enable <= 1'b0;
        dly_run_reg <= 1'b1;
        dly_cnt_reg <= dly_load;
      end else if (dly_run_reg) begin
        if (dly_cnt_reg == 20'h00000) begin
          driver_enable <= 1'b1;
          dly_run_reg <= 1'b0;
        end else begin
          dly_cnt_reg <= dly_cnt_reg - 20'h00001;
        end
      end
    end
  end

  // Analog selections and code; only the current limit is gated to the voltage output function.
  always_ff @(posedge clock) begin
    if (rst) begin
      voltage_range_bipolar <= 1'b0;
      current_limit_low <= 1'b0;
      dac_code <= 16'h0000;
    end else if (ce) begin
      voltage_range_bipolar <= setup_reg.voltage_range_sel;
      current_limit_low <= (func_reg == slew_ctrl_pkg::voltage_output)
                           & setup_reg.current_limit_sel;
      dac_code <= active_next;
    end
  end

  // Sticky interrupt status, write one to clear, a new event wins.
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= (irq_stat_reg & ~stat_clear) | events;
      if (wr_imask) begin
        irq_mask_reg <= dat_i[slew_ctrl_pkg::EV_COUNT-1:0];
      end
      irq <= irq_next;
    end
  end

endmodule : dac_output_slew_control

`default_nettype wire

// File: common/slew_ctrl_pkg.sv
package slew_ctrl_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // Setup register field positions and value after reset.
  localparam int SETUP_DEFER_BIT = 10;
  localparam int SETUP_SETTLED_BIT = 8;
  localparam logic [15:0] SETUP_RESET = 16'h0100;
  localparam logic [15:0] SETUP_RW_MASK = 16'h06FF;

  // Command key value that releases a held target code.
  localparam logic [15:0] UPDATE_KEY = 16'h00A5;
  // Code loaded when leaving high impedance; value is arbitrary.
  localparam logic [15:0] OFFSET_CODE = 16'h8000;

  // Channel function codes.
  typedef enum logic [1:0] {
    high_impedance_function,
    voltage_output,
    current_output,
    current_out_with_modem
  } channel_function_e;

  // Setup fields, bit 15 down to bit 0 of the setup register; bit 8 is the read-only settled flag.
  typedef struct packed {
    logic [4:0] unused;
    logic deferred_update_enable;
    logic drive_enable_delay_sel;
    logic compliant_slew_done_flag;
    logic voltage_range_sel;
    logic [1:0] slew_sel;
    logic [1:0] lin_step_sel;
    logic [1:0] lin_rate_sel;
    logic current_limit_sel;
  } setup_s;

  // Slew selections.
  localparam logic [1:0] SLEW_OFF = 2'h0;
  localparam logic [1:0] SLEW_LINEAR = 2'h1;
  localparam logic [1:0] compliant_slew_mode = 2'h2;

  // Interrupt status bit positions.
  localparam int EV_SETTLED = 0;
  localparam int EV_DRIVE_ON = 1;
  localparam int EV_LIN_DONE = 2;
  localparam int EV_COUNT = 3;

  // Timing, from the clock rate.
  localparam longint CLK_HZ = 250_000_000;
  localparam longint LONG_DLY_US = 4000;
  localparam longint SHORT_DLY_US = 200;
  localparam longint LONG_DLY_CYC = (LONG_DLY_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint SHORT_DLY_CYC = (SHORT_DLY_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint RATE0_HZ = 4800;
  localparam longint RATE1_HZ = 76800;
  localparam longint RATE2_HZ = 153600;
  localparam longint RATE3_HZ = 230400;
  localparam longint RATE0_CYC = CLK_HZ / RATE0_HZ;
  localparam logic [19:0] RATE1_CYC = 20'(CLK_HZ / RATE1_HZ);
  localparam logic [19:0] RATE2_CYC = 20'(CLK_HZ / RATE2_HZ);
  localparam logic [19:0] RATE3_CYC = 20'(CLK_HZ / RATE3_HZ);
  localparam longint COMPL_RATE_HZ = 4800;
  localparam longint COMPL_CYC = CLK_HZ / COMPL_RATE_HZ;
  localparam logic [15:0] COMPL_STEP = 16'h0040;

  // Linear step sizes in tenths of a percent of full scale.
  localparam longint FULL_SCALE = 65535;
  localparam logic [15:0] STEP0 = 16'(FULL_SCALE * 8 / 1000);
  localparam logic [15:0] STEP1 = 16'(FULL_SCALE * 15 / 1000);
  localparam logic [15:0] STEP2 = 16'(FULL_SCALE * 61 / 1000);
  localparam logic [15:0] STEP3 = 16'(FULL_SCALE * 222 / 1000);

endpackage : slew_ctrl_pkg

// File: verification/slew_checker.sv
`timescale 1ns/1ps
`default_nettype none
module slew_checker #(
  parameter longint SHORT_DLY = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [15:0] dac_code,
  input wire logic bias_enable,
  input wire logic driver_enable,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [31:0] wait_reg;
  // Counts the cycles that bias has stood while the driver is still off.
  always_ff @(posedge clock) begin
    if (rst || !bias_enable) begin
      wait_reg <= 32'h0;
    end else if (!driver_enable) begin
      wait_reg <= wait_reg + 32'h1;
    end
  end
  sequence req_taken;
    cyc_i && stb_i && !ack_o && ce;
  endsequence
  sequence bias_start;
    $rose(bias_enable);
  endsequence
  a_ack_follows: assert property (req_taken |=> ack_o) else $error("No ack after a taken request.");
  a_ack_pulse: assert property (ack_o && ce |=> !ack_o) else $error("Ack held past one cycle.");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("Ack without request.");
  a_read_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("Read data outside ack.");
  a_drive_bias: assert property (driver_enable |-> bias_enable) else $error("Driver on without bias.");
  a_drive_wait: assert property ($rose(driver_enable) |-> wait_reg >= SHORT_DLY)
    else $error("Driver enabled too early.");
  a_bias_first: assert property (bias_start |-> !driver_enable [*8]) else $error("Driver rose with bias.");
  a_reset_quiet: assert property ($fell(rst) |-> !ack_o && !irq && !bias_enable && dac_code == 16'h0000)
    else $error("Outputs not at reset values.");
endmodule : slew_checker
`default_nettype wire

// File: verification/analog_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_driver_model (
  input wire logic clock,
  input wire logic bias_enable,
  input wire logic driver_enable,
  output logic [31:0] on_delay
);
  logic [31:0] cnt_reg = 32'h0;
  // The output stage charges while biased; the charge time is latched when the driver turns on.
  always @(posedge clock) begin
    if (!bias_enable) cnt_reg <= 32'h0;
    else if (!driver_enable) cnt_reg <= cnt_reg + 32'h1;
    if ($rose(driver_enable)) on_delay <= cnt_reg;
  end
endmodule : analog_driver_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam longint LONG_N = 40;
  localparam longint SHORT_N = 10;
  localparam longint RATE_N = 20;
  localparam longint TICK_N = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd, on_delay;
  logic ack_o, bias_enable, driver_enable, voltage_range_bipolar, current_limit_low, irq;
  logic [15:0] dac_code, c1, c2;
  int errors = 0;
  int samples_checked = 0;
  int cycle_now = 0;
  int t1, t2;
  dac_output_slew_control #(.LONG_DLY(LONG_N), .SHORT_DLY(SHORT_N), .RATE0(RATE_N), .COMPL_TICK(TICK_N))
    u_dac_output_slew_control (.clock, .rst, .ce, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .dac_code, .bias_enable, .driver_enable, .voltage_range_bipolar, .current_limit_low, .irq);
  analog_driver_model u_analog_driver_model (.clock, .bias_enable, .driver_enable, .on_delay);
  // Clock and a cycle count used to time slew updates.
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) cycle_now <= cycle_now + 1;
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task give_up(input string what);
    errors++;
    $display("[FAIL] %s expected done seen timeout", what);
    close_out();
  endtask : give_up
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic bus cycle; read data is taken at the acknowledging edge.
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h3;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) give_up("bus ack");
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task wait_change(output logic [15:0] v, output int t);
    logic [15:0] p;
    int n;
    p = dac_code;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (dac_code === p && n < 60000);
    if (n >= 60000) give_up("dac change");
    v = dac_code;
    t = cycle_now;
  endtask : wait_change
  task t_drive(input logic [1:0] fn, input logic dsel, input longint exp);
    int n;
    n = 0;
    wb(1'b1, slew_ctrl_pkg::OFS_FUNC, 16'h0000);
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, {6'h00, dsel, 9'h000});
    wb(1'b1, slew_ctrl_pkg::OFS_FUNC, {14'h0000, fn});
    while (driver_enable !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) give_up("driver enable");
    @(posedge clock);
    check("drive delay", on_delay, 32'(exp));
    check("offset code", 32'(dac_code), 32'(slew_ctrl_pkg::OFFSET_CODE));
    wb(1'b0, slew_ctrl_pkg::OFS_STATE, 16'h0000);
    check("state word", rd, {14'h0000, 2'h3, slew_ctrl_pkg::OFFSET_CODE});
    wb(1'b0, slew_ctrl_pkg::OFS_SETUP, 16'h0000);
    check("settled low", 32'(rd[slew_ctrl_pkg::SETUP_SETTLED_BIT]), 32'h0);
    wb(1'b0, slew_ctrl_pkg::OFS_IRQ_STAT, 16'h0000);
    check("drive event", 32'(rd[slew_ctrl_pkg::EV_DRIVE_ON]), 32'h1);
    wb(1'b1, slew_ctrl_pkg::OFS_IRQ_STAT, 16'h0002);
  endtask : t_drive
  task t_regs_limits;
    wb(1'b0, slew_ctrl_pkg::OFS_SETUP, 16'h0000);
    check("setup reset", rd, 32'h0000_0100);
    wb(1'b0, 8'h1C, 16'h0000);
    check("unmapped read", rd, 32'h0);
    wb(1'b1, slew_ctrl_pkg::OFS_FUNC, 16'h0002);
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, 16'h0081);
    repeat (2) @(posedge clock);
    check("limit outside voltage", 32'(current_limit_low), 32'h0);
    check("range", 32'(voltage_range_bipolar), 32'h1);
    wb(1'b1, slew_ctrl_pkg::OFS_FUNC, 16'h0001);
    repeat (2) @(posedge clock);
    check("limit in voltage", 32'(current_limit_low), 32'h1);
  endtask : t_regs_limits
  task t_defer;
    c1 = dac_code;
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, 16'h0400);
    wb(1'b1, slew_ctrl_pkg::OFS_TARGET, 16'h1234);
    repeat (3) @(posedge clock);
    check("held code", 32'(dac_code), 32'(c1));
    wb(1'b1, slew_ctrl_pkg::OFS_KEY, slew_ctrl_pkg::UPDATE_KEY);
    repeat (3) @(posedge clock);
    check("released code", 32'(dac_code), 32'h1234);
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, 16'h0000);
    wb(1'b1, slew_ctrl_pkg::OFS_TARGET, 16'h4321);
    repeat (3) @(posedge clock);
    check("direct code", 32'(dac_code), 32'h4321);
  endtask : t_defer
  task t_linear(input logic [1:0] i, input longint period, input logic [15:0] step);
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, 16'h0000);
    wb(1'b1, slew_ctrl_pkg::OFS_TARGET, 16'h0000);
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, {9'h000, 2'b01, i, i, 1'b0});
    wb(1'b1, slew_ctrl_pkg::OFS_TARGET, 16'hFFFF);
    wait_change(c1, t1);
    wait_change(c2, t2);
    check("linear step", 32'(c2 - c1), 32'(step));
    check("linear period", 32'(t2 - t1), 32'(period));
  endtask : t_linear
  task t_clamp_irq;
    int n;
    n = 0;
    // With the clock enable low the code must stand still across two slew periods.
    c1 = dac_code;
    ce <= 1'b0;
    repeat (2500) @(posedge clock);
    check("frozen code", 32'(dac_code), 32'(c1));
    ce <= 1'b1;
    while (dac_code !== 16'hFFFF && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20000) give_up("clamp");
    check("clamped code", 32'(dac_code), 32'hFFFF);
    wb(1'b0, slew_ctrl_pkg::OFS_IRQ_STAT, 16'h0000);
    check("done flag", 32'(rd[slew_ctrl_pkg::EV_LIN_DONE]), 32'h1);
    wb(1'b1, slew_ctrl_pkg::OFS_IRQ_MASK, 16'h0004);
    repeat (2) @(posedge clock);
    check("irq raised", 32'(irq), 32'h1);
    wb(1'b1, slew_ctrl_pkg::OFS_IRQ_STAT, 16'h0004);
    repeat (2) @(posedge clock);
    check("irq cleared", 32'(irq), 32'h0);
    wb(1'b1, slew_ctrl_pkg::OFS_IRQ_MASK, 16'h0000);
  endtask : t_clamp_irq
  task t_compliant;
    int n;
    n = 0;
    do begin
      wb(1'b0, slew_ctrl_pkg::OFS_SETUP, 16'h0000);
      n++;
    end while (rd[slew_ctrl_pkg::SETUP_SETTLED_BIT] !== 1'b1 && n < 5000);
    if (n >= 5000) give_up("settled");
    check("settled", 32'(rd[slew_ctrl_pkg::SETUP_SETTLED_BIT]), 32'h1);
    wb(1'b0, slew_ctrl_pkg::OFS_IRQ_STAT, 16'h0000);
    check("settled event", 32'(rd[slew_ctrl_pkg::EV_SETTLED]), 32'h1);
    wb(1'b1, slew_ctrl_pkg::OFS_SETUP, 16'h0040);
    wb(1'b1, slew_ctrl_pkg::OFS_TARGET, 16'hFF00);
    wait_change(c1, t1);
    check("compliant step", 32'(c1), 32'hFFBF);
    wait_change(c2, t2);
    check("compliant tick", 32'(t2 - t1), 32'(TICK_N));
  endtask : t_compliant
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_regs_limits();
    t_drive(2'h1, 1'b0, SHORT_N);
    t_drive(2'h2, 1'b0, SHORT_N);
    t_drive(2'h3, 1'b0, LONG_N);
    t_drive(2'h3, 1'b1, SHORT_N);
    t_defer();
    t_linear(2'h0, RATE_N, slew_ctrl_pkg::STEP0);
    t_linear(2'h1, slew_ctrl_pkg::RATE1_CYC, slew_ctrl_pkg::STEP1);
    t_linear(2'h2, slew_ctrl_pkg::RATE2_CYC, slew_ctrl_pkg::STEP2);
    t_linear(2'h3, slew_ctrl_pkg::RATE3_CYC, slew_ctrl_pkg::STEP3);
    t_clamp_irq();
    t_compliant();
    close_out();
  end
endmodule : tb
bind dac_output_slew_control slew_checker #(.SHORT_DLY(SHORT_DLY)) u_slew_checker (.clock, .rst, .ce, .cyc_i,
  .stb_i, .ack_o, .dat_o, .dac_code, .bias_enable, .driver_enable, .irq);
`default_nettype wire
